// file: src/xdw_cmd.sv
// Purpose: task-file registers and command engine for the extended dma write
// Assumes: the dma data mover is outside; it reports done and error events
// Notes: unknown command codes are aborted when not busy; while busy they are ignored
`timescale 1ns/1ps
module xdw_cmd
  import xdw_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // media and fault condition inputs
  input wire logic removable,
  input wire logic media_wp,
  input wire logic media_change_evt,
  input wire logic media_change_req,
  input wire logic media_absent,
  input wire logic dev_fault,
  // data mover events
  input wire logic xfer_done,
  input wire logic xfer_err,
  input wire logic [47:0] xfer_err_addr,
  input wire logic err_ultra,
  input wire logic err_crc,
  input wire logic err_not_found,
  input wire logic err_range,
  // command outputs
  output logic xfer_start,
  output logic [47:0] xfer_addr,
  output logic [16:0] xfer_len
);
  import xdw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  xdw_state_e state_reg;
  logic [7:0] cur_reg [5];
  logic [7:0] prev_reg [5];
  logic [7:0] drive_reg, ctrl_reg, err_reg, stat_reg, rdata_reg;
  logic mc_pend_reg, start_reg;
  logic [47:0] addr_reg;
  logic [16:0] len_reg;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire cmd_wr = reg_wr && reg_addr == XDW_OFS_CMD;
  wire busy = stat_reg[XDW_ST_BUSY];
  wire is_write_ext = reg_wdata == XDW_CMD_WRITE_EXT;
  wire is_query = reg_wdata == XDW_CMD_MEDIA_QUERY;
  wire upper_byte_select = ctrl_reg[XDW_CTRL_HOB];
  wire [15:0] cnt16 = {prev_reg[1], cur_reg[1]};
  wire [47:0] start_addr = {prev_reg[4], prev_reg[3], prev_reg[2],
                            cur_reg[4], cur_reg[3], cur_reg[2]};
  wire [16:0] len_next = (cnt16 == 16'h0000) ? XDW_FULL_LEN : {1'b0, cnt16};
  wire mc_now = mc_pend_reg || media_change_evt;
  wire media_ok = !(removable && (media_wp || mc_now || media_absent ||
                                  media_change_req));
  wire done_ev = state_reg == XDW_XFER && xfer_done;
  wire fail_ev = state_reg == XDW_XFER && xfer_err;
  wire start_ev = cmd_wr && !busy && is_write_ext && media_ok;
  wire media_err = cmd_wr && !busy && is_write_ext && !media_ok;
  wire abort_cmd = cmd_wr && !busy && !is_write_ext && !is_query;
  wire media_access = start_ev || (cmd_wr && !busy && is_query);
  wire [7:0] err_media = {1'b0,
                          removable && media_wp,
                          removable && mc_now,
                          1'b0,
                          removable && media_change_req,
                          1'b0,
                          removable && media_absent,
                          1'b0};
  wire nf_bit = err_not_found || (err_range && !err_ultra);
  wire [7:0] err_xfer = {err_ultra && err_crc,
                         1'b0,
                         1'b0,
                         nf_bit,
                         1'b0,
                         err_ultra || (err_range && !nf_bit),
                         1'b0,
                         1'b0};
  wire [7:0] err_next = fail_ev ? err_xfer : media_err ? err_media :
                        abort_cmd ? 8'h04 : XDW_ZERO8;
  wire err_any = |err_next;
  wire ending = done_ev || fail_ev || media_err || abort_cmd;
  wire [7:0] stat_end = {1'b0, 1'b1, dev_fault && err_any, 1'b0, 3'b000, err_any};
  wire [7:0] stat_go = {1'b1, 1'b0, 1'b0, 1'b0, 3'b000, 1'b0};
  wire [7:0] stat_next = start_ev ? stat_go : ending ? stat_end : stat_reg;
  wire [7:0] unit_bit = {3'b000, drive_reg[XDW_DRV_UNIT], 4'h0};
  wire [2:0] ri = reg_addr - XDW_OFS_COUNT;
  wire in_param = reg_addr >= XDW_OFS_COUNT && reg_addr <= XDW_OFS_AHIGH;
  wire [7:0] rd_param = upper_byte_select ? prev_reg[ri + 3'd1] : cur_reg[ri + 3'd1];
  wire [7:0] rd_next = !reg_rd ? XDW_ZERO8 :
                       reg_addr == XDW_OFS_FEATURE ? err_reg :
                       reg_addr == XDW_OFS_CMD ? stat_reg :
                       reg_addr == XDW_OFS_DRIVE ? (drive_reg & 8'h50) | unit_bit :
                       reg_addr == XDW_OFS_CTRL ? ctrl_reg :
                       in_param ? rd_param : XDW_ZERO8;

  ////////////////////////////////////////////////////////////////////////////
  // parameter history, one entry per register
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_param
      wire wr_hit = reg_wr && !busy && reg_addr == XDW_OFS_FEATURE + 3'(g);
      // RULE10 failing address
      wire ld_fail = fail_ev && g >= 2;
      localparam int LO_BIT = (g >= 2) ? (g - 2) * 8 : 0;
      localparam int HI_BIT = (g >= 2) ? (g + 1) * 8 : 0;
      // RULE3 current and previous
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          cur_reg[g] <= XDW_ZERO8;
          prev_reg[g] <= XDW_ZERO8;
        end else if (ld_fail) begin
          // RULE11 failing address halves
          cur_reg[g] <= xfer_err_addr[LO_BIT +: 8];
          prev_reg[g] <= xfer_err_addr[HI_BIT +: 8];
        end else if (wr_hit) begin
          cur_reg[g] <= reg_wdata;
          prev_reg[g] <= cur_reg[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // state and status
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= XDW_IDLE;
      stat_reg <= 8'h40;
      err_reg <= XDW_ZERO8;
      drive_reg <= XDW_ZERO8;
      ctrl_reg <= XDW_ZERO8;
      mc_pend_reg <= 1'b0;
      start_reg <= 1'b0;
      addr_reg <= 48'h0000_0000_0000;
      len_reg <= 17'h0_0000;
      rdata_reg <= XDW_ZERO8;
    end else begin
      rdata_reg <= rd_next;
      start_reg <= start_ev;
      // RULE9 completion status
      // RULE19 error status
      stat_reg <= stat_next;
      if (start_ev || ending) begin
        // RULE12 crc flag
        // RULE13 RULE15 RULE17 RULE18 error bits
        err_reg <= err_next;
      end
      if (reg_wr && reg_addr == XDW_OFS_DRIVE && !busy) begin
        drive_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == XDW_OFS_CTRL) begin
        ctrl_reg <= reg_wdata;
      end
      // RULE14 report clears change state
      if (media_err) begin
        mc_pend_reg <= 1'b0;
      end else if (media_change_evt) begin
        mc_pend_reg <= 1'b1;
      end
      // RULE16 request bit cleared by query or access, and by an aborted unknown command
      if (media_access) begin
        err_reg[XDW_ER_MCR] <= 1'b0;
      end
      if (start_ev) begin
        // RULE1 accept code
        state_reg <= XDW_XFER;
        // RULE4 transfer length
        len_reg <= len_next;
        // RULE5 starting address
        addr_reg <= start_addr;
      end else if (done_ev || fail_ev) begin
        state_reg <= XDW_IDLE;
      end
    end
  end

  // RULE8 byte select on reads
  assign reg_rdata = rdata_reg;
  assign xfer_start = start_reg;
  assign xfer_addr = addr_reg;
  assign xfer_len = len_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_START_LEN: assert property (@(posedge core_clk) disable iff (rst)
    start_ev && cnt16 == 16'h0000 |=> xfer_len == XDW_FULL_LEN) // RULE4
    else $error("zero count did not give full length");
  AST_START_ADDR: assert property (@(posedge core_clk) disable iff (rst)
    start_ev |=> xfer_addr == $past(start_addr) && xfer_start) // RULE5
    else $error("start address wrong");
  AST_CODE_START: assert property (@(posedge core_clk) disable iff (rst)
    xfer_start |-> $past(reg_wdata) == XDW_CMD_WRITE_EXT) // RULE1
    else $error("started on a wrong code");
  AST_OK_STATUS: assert property (@(posedge core_clk) disable iff (rst)
    done_ev |=> stat_reg == 8'h40) // RULE9
    else $error("bad completion status");
  AST_ERR_SUMMARY: assert property (@(posedge core_clk) disable iff (rst)
    ending |=> stat_reg[XDW_ST_ERR] == (err_reg != XDW_ZERO8)
               && !stat_reg[XDW_ST_BUSY] && stat_reg[XDW_ST_READY]) // RULE19
    else $error("error summary mismatch");
  AST_FAIL_ADDR: assert property (@(posedge core_clk) disable iff (rst)
    fail_ev |=> {prev_reg[4], prev_reg[3], prev_reg[2], cur_reg[4], cur_reg[3],
                 cur_reg[2]} == $past(xfer_err_addr)) // RULE10
    else $error("failing address not loaded");
  AST_HOB_READ: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == XDW_OFS_ALOW && !busy |=>
      reg_rdata == ($past(upper_byte_select) ? prev_reg[2] : cur_reg[2]) || $past(fail_ev)) // RULE8
    else $error("byte select read wrong");
  AST_HISTORY: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == XDW_OFS_COUNT && !busy && !fail_ev |=>
      prev_reg[1] == $past(cur_reg[1]) && cur_reg[1] == $past(reg_wdata)) // RULE3
    else $error("history not kept");
  AST_CRC_BIT: assert property (@(posedge core_clk) disable iff (rst)
    fail_ev && err_ultra && err_crc |=> err_reg[XDW_ER_CRC]
      && err_reg[XDW_ER_COMMAND_ABORTED]) // RULE12
    else $error("crc bits not set");

  AST_LEN_NONZERO: assert property (@(posedge core_clk) disable iff (rst) // RULE4
    start_ev && cnt16 != 16'h0000 |=> xfer_len == {1'b0, $past(cnt16)})
    else $error("nonzero count gave wrong length");

  AST_START_PULSE: assert property (@(posedge core_clk) disable iff (rst) // RULE1
    xfer_start |=> !xfer_start)
    else $error("start pulse too long");

  AST_BUSY_ON_START: assert property (@(posedge core_clk) disable iff (rst) // RULE1
    start_ev |=> stat_reg == 8'h80)
    else $error("busy status not shown on start");

  AST_NO_START_BAD: assert property (@(posedge core_clk) disable iff (rst) // RULE1
    cmd_wr && !is_write_ext |=> !xfer_start)
    else $error("started on another code");

  AST_NO_START_BUSY: assert property (@(posedge core_clk) disable iff (rst) // RULE1
    cmd_wr && busy |=> !xfer_start)
    else $error("started while busy");

  AST_OK_ERR_CLEAR: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    done_ev |=> err_reg == XDW_ZERO8)
    else $error("error flags left after success");

  AST_OK_IDLE: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    done_ev |=> state_reg == XDW_IDLE)
    else $error("engine not idle after success");

  AST_UNIT_READ: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    reg_rd && reg_addr == XDW_OFS_DRIVE |=>
      reg_rdata[XDW_DRV_UNIT] == $past(drive_reg[XDW_DRV_UNIT]))
    else $error("unit select not reflected");

  AST_HOB_PREV: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    reg_rd && reg_addr == XDW_OFS_AHIGH && upper_byte_select |=> reg_rdata == $past(prev_reg[4]))
    else $error("high byte read with select set wrong");

  AST_CUR_COUNT: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    reg_rd && reg_addr == XDW_OFS_COUNT && !upper_byte_select |=> reg_rdata == $past(cur_reg[1]))
    else $error("count read with select clear wrong");

  AST_HOB_MID: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    reg_rd && reg_addr == XDW_OFS_AMID && upper_byte_select |=> reg_rdata == $past(prev_reg[3]))
    else $error("mid byte read with select set wrong");

  AST_RDATA_IDLE: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    !reg_rd |=> reg_rdata == XDW_ZERO8)
    else $error("read data outside read slot");

  AST_FAIL_LOW: assert property (@(posedge core_clk) disable iff (rst) // RULE11
    fail_ev |=> cur_reg[2] == $past(xfer_err_addr[7:0])
      && prev_reg[2] == $past(xfer_err_addr[31:24]))
    else $error("failing low byte pair wrong");

  AST_FAIL_MID: assert property (@(posedge core_clk) disable iff (rst) // RULE11
    fail_ev |=> cur_reg[3] == $past(xfer_err_addr[15:8])
      && prev_reg[3] == $past(xfer_err_addr[39:32]))
    else $error("failing mid byte pair wrong");

  AST_FAIL_HIGH: assert property (@(posedge core_clk) disable iff (rst) // RULE11
    fail_ev |=> cur_reg[4] == $past(xfer_err_addr[23:16])
      && prev_reg[4] == $past(xfer_err_addr[47:40]))
    else $error("failing high byte pair wrong");

  AST_FAIL_IDLE: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    fail_ev |=> state_reg == XDW_IDLE && !stat_reg[XDW_ST_BUSY])
    else $error("error did not end the command");

  AST_FAIL_KEEP_COUNT: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    fail_ev |=> $stable(cur_reg[1]))
    else $error("count touched on error");

  AST_WP_BIT: assert property (@(posedge core_clk) disable iff (rst) // RULE13
    media_err && media_wp |=> err_reg[XDW_ER_WP])
    else $error("write protect bit missing");

  AST_MEDIA_NO_START: assert property (@(posedge core_clk) disable iff (rst) // RULE13
    media_err |=> !xfer_start && stat_reg[XDW_ST_ERR])
    else $error("media error did not refuse the command");

  AST_MC_BIT: assert property (@(posedge core_clk) disable iff (rst) // RULE14
    media_err && mc_now |=> err_reg[XDW_ER_MC] && !mc_pend_reg)
    else $error("media change not reported or not cleared");

  AST_MC_SET: assert property (@(posedge core_clk) disable iff (rst) // RULE14
    media_change_evt && !media_err |=> mc_pend_reg)
    else $error("media change not remembered");

  AST_NF_BIT: assert property (@(posedge core_clk) disable iff (rst) // RULE15
    fail_ev && err_not_found |=> err_reg[XDW_ER_NF])
    else $error("not found bit missing");

  AST_RANGE_BIT: assert property (@(posedge core_clk) disable iff (rst) // RULE15
    fail_ev && err_range |=> err_reg[XDW_ER_NF] != err_reg[XDW_ER_COMMAND_ABORTED]
      || err_reg[XDW_ER_NF] && err_ultra)
    else $error("range error reported wrongly");

  AST_MCR_BIT: assert property (@(posedge core_clk) disable iff (rst) // RULE16
    media_err && media_change_req |=> err_reg[XDW_ER_MCR])
    else $error("change request bit missing");

  AST_MCR_HOLD: assert property (@(posedge core_clk) disable iff (rst) // RULE16
    !(start_ev || ending || media_access) |=> $stable(err_reg))
    else $error("error flags changed without a cause");

  AST_MCR_QUERY: assert property (@(posedge core_clk) disable iff (rst) // RULE16
    cmd_wr && !busy && is_query |=> !err_reg[XDW_ER_MCR])
    else $error("query did not clear change request");

  AST_ABORT_BIT: assert property (@(posedge core_clk) disable iff (rst) // RULE17
    abort_cmd |=> err_reg == 8'h04)
    else $error("abort flags wrong");

  AST_ULTRA_COMMAND_ABORTED: assert property (@(posedge core_clk) disable iff (rst) // RULE17
    fail_ev && err_ultra |=> err_reg[XDW_ER_COMMAND_ABORTED])
    else $error("ultra error without abort bit");

  AST_NM_BIT: assert property (@(posedge core_clk) disable iff (rst) // RULE18
    media_err && media_absent |=> err_reg[XDW_ER_NM])
    else $error("no media bit missing");

  AST_FAULT_BIT: assert property (@(posedge core_clk) disable iff (rst) // RULE19
    ending |=> stat_reg[XDW_ST_FAULT] == $past(dev_fault && err_any))
    else $error("fault bit wrong");

  AST_ERR_NO_XREQ: assert property (@(posedge core_clk) disable iff (rst) // RULE19
    ending |=> !stat_reg[XDW_ST_XREQ])
    else $error("transfer request left set");

  AST_NO_WR_BUSY: assert property (@(posedge core_clk) disable iff (rst) // RULE3
    busy && reg_wr && reg_addr == XDW_OFS_COUNT |=> $stable(cur_reg[1]))
    else $error("count written while busy");

  AST_HISTORY_ADDR: assert property (@(posedge core_clk) disable iff (rst) // RULE3
    reg_wr && reg_addr == XDW_OFS_AHIGH && !busy |=>
      prev_reg[4] == $past(cur_reg[4]) && cur_reg[4] == $past(reg_wdata))
    else $error("address history not kept");

  AST_CRC_ONLY_ULTRA: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    fail_ev && !err_ultra |=> !err_reg[XDW_ER_CRC])
    else $error("crc bit outside ultra transfer");

  COV_OK: cover property (@(posedge core_clk) disable iff (rst) done_ev);
  COV_FAIL: cover property (@(posedge core_clk) disable iff (rst) fail_ev);
  COV_MEDIA: cover property (@(posedge core_clk) disable iff (rst) media_err);
  COV_ABORT: cover property (@(posedge core_clk) disable iff (rst) abort_cmd);
endmodule

// file: src/xdw_pkg.sv
// Purpose: constants for the extended-address dma write command block
// Assumes: register port with 3-bit address, 8-bit data, read data one cycle later
// Notes: register offsets are local choices
// Operation
// RULE1 - command code 35h is accepted as the extended-address dma write
// RULE2 - host never sends this command to a packet-command device
// RULE3 - each parameter register keeps current and previous written byte
// RULE4 - length is previous count high, current count low; zero means 65,536
// RULE5 - address low three bytes from current, upper three from previous
// RULE6 - host sets address-mode bit and names the target unit
// RULE7 - host waits for unit ready and programs its dma channel first
// RULE8 - upper byte select clear reads current bytes, set reads previous
// RULE9 - success clears busy, fault, transfer request, error; sets ready
// RULE10 - unrecoverable error ends command, failing address loaded to registers
// RULE11 - failing address low half with select clear, high half with set
// RULE12 - error bit 7 on link crc fault during ultra dma
// RULE13 - error bit 6 when removable media is write protected
// RULE14 - error bit 5 on media change; reporting clears internal change state
// RULE15 - error bit 4 when address not found or out of range without abort
// RULE16 - error bit 3 on media change request; cleared by query or access
// RULE17 - error bit 2 on unsupported command, ultra dma error, range fallback
// RULE18 - error bit 1 when no media present
// RULE19 - error: clear busy and request, set ready, fault on fault, summary
// RULE20 - host writes high byte first, low second, command last
package xdw_pkg;
  localparam logic [2:0] XDW_OFS_FEATURE = 3'h1;
  localparam logic [2:0] XDW_OFS_COUNT = 3'h2;
  localparam logic [2:0] XDW_OFS_ALOW = 3'h3;
  localparam logic [2:0] XDW_OFS_AMID = 3'h4;
  localparam logic [2:0] XDW_OFS_AHIGH = 3'h5;
  localparam logic [2:0] XDW_OFS_DRIVE = 3'h6;
  localparam logic [2:0] XDW_OFS_CMD = 3'h7;
  localparam logic [2:0] XDW_OFS_CTRL = 3'h0;
  localparam logic [7:0] XDW_CMD_WRITE_EXT = 8'h35;
  localparam logic [7:0] XDW_CMD_MEDIA_QUERY = 8'hDA;
  localparam int XDW_ST_BUSY = 7;
  localparam int XDW_ST_READY = 6;
  localparam int XDW_ST_FAULT = 5;
  localparam int XDW_ST_XREQ = 3;
  localparam int XDW_ST_ERR = 0;
  localparam int XDW_ER_CRC = 7;
  localparam int XDW_ER_WP = 6;
  localparam int XDW_ER_MC = 5;
  localparam int XDW_ER_NF = 4;
  localparam int XDW_ER_MCR = 3;
  localparam int XDW_ER_COMMAND_ABORTED = 2;
  localparam int XDW_ER_NM = 1;
  localparam int XDW_DRV_LBA = 6;
  localparam int XDW_DRV_UNIT = 4;
  localparam int XDW_CTRL_HOB = 7;
  localparam logic [7:0] XDW_ZERO8 = 8'h00;
  localparam logic [16:0] XDW_FULL_LEN = 17'h1_0000;
  typedef enum logic [1:0] {XDW_IDLE, XDW_XFER} xdw_state_e;
endpackage

// file: tb/xdw_mover.sv
// Purpose: data mover stand-in answering each command start
// Assumes: one transfer at a time, delay of at least one cycle
// Notes: failing address shows only during the error pulse
`timescale 1ns/1ps
module xdw_mover (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // command side
  input wire logic xfer_start,
  input wire logic fail,
  input wire logic [7:0] delay,
  input wire logic [47:0] fail_addr,
  // event side
  output logic xfer_done,
  output logic xfer_err,
  output logic [47:0] xfer_err_addr
);
  logic [7:0] cnt_reg;
  assign xfer_err_addr = xfer_err ? fail_addr : ~fail_addr;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      xfer_done <= 1'b0;
      xfer_err <= 1'b0;
    end else if (xfer_start) begin
      cnt_reg <= delay;
    end else begin
      cnt_reg <= (cnt_reg == 8'h00) ? 8'h00 : cnt_reg - 8'h01;
      xfer_done <= (cnt_reg == 8'h01) && !fail;
      xfer_err <= (cnt_reg == 8'h01) && fail;
    end
  end
endmodule

// file: tb/tb_xdw_cmd.sv
// Purpose: self-checking bench for the extended dma write command block
// Assumes: host side driven here, data mover modelled separately
// Notes: seed fixed for repeatable random counts and addresses
`timescale 1ns/1ps
module tb_xdw_cmd;
  import xdw_pkg::*;
  logic core_clk, rst, reg_wr, reg_rd, xfer_start, xfer_done, xfer_err, err_range, evt;
  logic removable, media_wp, media_change_req, media_absent, dev_fault, fail;
  logic err_ultra, err_crc, err_not_found;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd, dly;
  logic [8:0] cnd;
  logic [15:0] c;
  logic [16:0] xfer_len;
  logic [47:0] xfer_err_addr, xfer_addr, a, fa;
  int failures, n_tests;
  assign {removable, media_wp, media_change_req, media_absent, dev_fault} = cnd[8:4];
  assign {fail, err_ultra, err_crc, err_not_found} = cnd[3:0];
  xdw_cmd xdw_cmd_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .removable(removable), .media_wp(media_wp), .media_change_evt(evt),
    .media_change_req(media_change_req), .media_absent(media_absent),
    .dev_fault(dev_fault), .xfer_done(xfer_done), .xfer_err(xfer_err),
    .xfer_err_addr(xfer_err_addr), .err_ultra(err_ultra), .err_crc(err_crc),
    .err_not_found(err_not_found), .err_range(err_range), .xfer_start(xfer_start),
    .xfer_addr(xfer_addr), .xfer_len(xfer_len));
  xdw_mover xdw_mover_i (.core_clk(core_clk), .rst(rst), .xfer_start(xfer_start),
    .fail(fail), .delay(dly), .fail_addr(fa), .xfer_done(xfer_done),
    .xfer_err(xfer_err), .xfer_err_addr(xfer_err_addr));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  function automatic logic [16:0] exp_len(input logic [15:0] v);
    return (v == 16'h0000) ? XDW_FULL_LEN : {1'b0, v};
  endfunction
  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] ex);
    n_tests++;
    if (seen !== ex) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [2:0] ad, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdback(input logic [2:0] first, input int n, input logic [31:0] lo,
                        input logic [31:0] hi);
    for (int h = 0; h < 2; h++) begin
      wr(XDW_OFS_CTRL, h ? 8'h80 : 8'h00);
      for (int i = 0; i < n; i++) begin
        rdr(3'(first + i), rd);
        check("param", rd, h ? hi[8*i +: 8] : lo[8*i +: 8]);
      end
    end
    wr(XDW_OFS_CTRL, 8'h00);
  endtask
  task automatic run(input string nm, input logic [7:0] cmd, input logic go,
                     input logic [7:0] msk, input logic [7:0] er, input logic [7:0] st);
    int k;
    dly <= 8'(1 + $urandom % 40);
    wr(XDW_OFS_CMD, cmd);
    #1 check("start", xfer_start, go);
    if (go) check("len", xfer_len, exp_len(c));
    if (go) check("addr", xfer_addr, a);
    for (k = 0; k < 100; k++) begin
      rdr(XDW_OFS_CMD, rd);
      if (rd[7] === 1'b0) break;
    end
    if (k == 100) begin
      failures++;
      give_verdict();
    end
    check("status", rd, st);
    rdr(XDW_OFS_FEATURE, rd);
    check("error", rd & msk, er);
    $display("test %s done", nm);
  endtask
  initial begin
    {reg_wr, reg_rd, evt, err_range, cnd, reg_addr, reg_wdata, dly} = '0;
    {c, a, fa} = '0;
    failures = 0;
    n_tests = 0;
    void'($urandom(89422));
    rst = 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rdr(XDW_OFS_CMD, rd);
    check("reset status", rd, 8'h40);
    for (int t = 0; t < 6; t++) begin
      c = (t == 0) ? 16'h0000 : 16'($urandom);
      a = {16'($urandom), 32'($urandom)};
      // disk unit, high first, lba, ready
      wr(XDW_OFS_COUNT, c[15:8]);
      wr(XDW_OFS_COUNT, c[7:0]);
      for (int i = 0; i < 3; i++) begin
        wr(3'(XDW_OFS_ALOW + i), a[24 + 8*i +: 8]);
        wr(3'(XDW_OFS_ALOW + i), a[8*i +: 8]);
      end
      wr(XDW_OFS_DRIVE, 8'h50);
      rdr(XDW_OFS_DRIVE, rd);
      check("drive", rd, 8'h50);
      rdback(XDW_OFS_COUNT, 4, {a[23:0], c[7:0]}, {a[47:24], c[15:8]});
      run("ok", XDW_CMD_WRITE_EXT, 1'b1, 8'hff, 8'h00, 8'h40);
    end
    @(posedge core_clk);
    cnd <= 9'h01e;
    fa = {16'($urandom), 32'($urandom)};
    run("crc", XDW_CMD_WRITE_EXT, 1'b1, 8'hff, 8'h84, 8'h61);
    rdback(XDW_OFS_ALOW, 3, {8'h00, fa[23:0]}, {8'h00, fa[47:24]});
    a = fa;
    @(posedge core_clk);
    cnd <= 9'h009;
    run("notfound", XDW_CMD_WRITE_EXT, 1'b1, 8'hff, 8'h10, 8'h41);
    @(posedge core_clk);
    cnd <= 9'h008;
    err_range <= 1'b1;
    run("range", XDW_CMD_WRITE_EXT, 1'b1, 8'hff, 8'h10, 8'h41);
    err_range <= 1'b0;
    @(posedge core_clk);
    cnd <= 9'h180;
    run("wp", XDW_CMD_WRITE_EXT, 1'b0, 8'h40, 8'h40, 8'h41);
    @(posedge core_clk);
    cnd <= 9'h120;
    run("absent", XDW_CMD_WRITE_EXT, 1'b0, 8'h02, 8'h02, 8'h41);
    @(posedge core_clk);
    cnd <= 9'h140;
    run("chreq", XDW_CMD_WRITE_EXT, 1'b0, 8'h08, 8'h08, 8'h41);
    @(posedge core_clk);
    cnd <= 9'h100;
    run("query", XDW_CMD_MEDIA_QUERY, 1'b0, 8'h08, 8'h00, 8'h41);
    @(posedge core_clk);
    evt <= 1'b1;
    @(posedge core_clk);
    evt <= 1'b0;
    run("changed", XDW_CMD_WRITE_EXT, 1'b0, 8'h20, 8'h20, 8'h41);
    run("after", XDW_CMD_WRITE_EXT, 1'b1, 8'hff, 8'h00, 8'h40);
    run("unknown", 8'h11, 1'b0, 8'hff, 8'h04, 8'h41);
    give_verdict();
  end
endmodule
